//--- rtl/event_irq_and_sw_transfer_trigger.sv
/*
  Event interrupt flags with enables and the software trigger register
  for the transfer controller, reached over a plain 8-bit register port.
  Assumes all inputs synchronous to clk_i; event and transfer controller
  inputs are one-cycle pulses except interrupt_select_bit_i and count_end_i.

*/
`timescale 1ns/1ps
`include "evirq_cfg.svh"
module event_irq_and_sw_transfer_trigger (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      reset_n_i,
  // Register port
  input  wire logic [`EVIRQ_ADDR_W-1:0]  addr_i,
  input  wire logic [7:0]                wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [7:0]                rdata_o,
  // Event sources
  input  wire logic                      event_second_i,
  input  wire logic                      event_first_i,
  // Interrupt requests
  output logic                           irq_second_o,
  output logic                           irq_first_o,
  // Transfer controller, event activations
  input  wire logic                      xfer_ack_second_i,
  input  wire logic                      xfer_ack_first_i,
  input  wire logic                      interrupt_select_bit_i,
  // Transfer controller, software activation
  input  wire logic                      sw_run_done_i,
  input  wire logic                      count_end_i,
  input  wire logic                      sw_end_irq_i,
  input  wire logic                      select_zero_wr_i,
  output logic                           sw_start_o,
  output logic                           sw_enable_o,
  output logic      [15:0]               sw_vector_addr_o
);

  // ***********************************************************
  // Reset release
  // ***********************************************************
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ***********************************************************
  // Helpers
  // ***********************************************************
  function automatic logic [15:0] vec_addr(input logic [6:0] num);
    vec_addr = `EVIRQ_VEC_BASE + {8'h00, num, 1'b0};
  endfunction

  // ***********************************************************
  // Address decode
  // ***********************************************************
  logic wr_status;
  logic wr_vector;
  logic rd_status;
  logic rd_vector;

  always_comb begin
    wr_status = 1'b0;
    wr_vector = 1'b0;
    rd_status = 1'b0;
    rd_vector = 1'b0;
    if (addr_i == `EVIRQ_STATUS_ADDR) begin
      wr_status = wr_i;
      rd_status = rd_i;
    end else if (addr_i == `EVIRQ_VECTOR_ADDR) begin
      wr_vector = wr_i;
      rd_vector = rd_i;
    end
  end

  // ***********************************************************
  // Sub-blocks
  // ***********************************************************
  evirq_if lnk ();

  event_flag_bank event_flag_bank_inst (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .lnk     (lnk.flag_mp)
  );

  sw_trigger_ctrl sw_trigger_ctrl_inst (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .lnk     (lnk.trig_mp)
  );

  // Flag bank requests
  assign lnk.ev_set[`EVIRQ_BIT_FLAG_SECOND] = event_second_i;
  assign lnk.ev_set[`EVIRQ_BIT_FLAG_FIRST]  = event_first_i;
  assign lnk.rd_arm  = {rd_status, rd_status};
  assign lnk.wr_zero = {wr_status & ~wdata_i[`EVIRQ_BIT_FLAG_SECOND],
                        wr_status & ~wdata_i[`EVIRQ_BIT_FLAG_FIRST]};
  // Only the flag itself clears; nothing goes back to the source
  assign lnk.xfer_clr = {xfer_ack_second_i & ~interrupt_select_bit_i,
                         xfer_ack_first_i & ~interrupt_select_bit_i};

  // Trigger controller requests
  assign lnk.sw_wr_one     = wr_vector & wdata_i[`EVIRQ_BIT_SW_ENABLE];
  assign lnk.sw_wr_zero    = wr_vector & ~wdata_i[`EVIRQ_BIT_SW_ENABLE];
  assign lnk.run_done      = sw_run_done_i;
  assign lnk.count_end     = count_end_i;
  assign lnk.interrupt_select_bit = interrupt_select_bit_i;
  assign lnk.end_irq              = sw_end_irq_i;
  assign lnk.select_zero_wr       = select_zero_wr_i;

  // ***********************************************************
  // Register state
  // ***********************************************************
  evirq_pkg::top_regs_t cur_reg;
  evirq_pkg::top_regs_t cur_next;

  always_comb begin
    cur_next       = cur_reg;
    cur_next.rdata = 8'h00;
    if (wr_status) begin
      cur_next.enable = {wdata_i[`EVIRQ_BIT_EN_SECOND],
                         wdata_i[`EVIRQ_BIT_EN_FIRST]};
    end
    if (wr_vector && !lnk.sw_enable) begin
      cur_next.vector = wdata_i[`EVIRQ_VEC_MSB:0];
    end
    cur_next.vaddr = vec_addr(cur_next.vector);
    if (rd_status) begin
      cur_next.rdata = {4'h0, cur_reg.enable, lnk.flag};
    end else if (rd_vector) begin
      cur_next.rdata = {lnk.sw_enable, cur_reg.vector};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg.rdata  <= 8'h00;
      cur_reg.enable <= 2'b00;
      cur_reg.vector <= 7'h00;
      cur_reg.vaddr  <= `EVIRQ_VEC_BASE;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign rdata_o          = cur_reg.rdata;
  assign irq_second_o     = lnk.flag[1] & cur_reg.enable[1];
  assign irq_first_o      = lnk.flag[0] & cur_reg.enable[0];
  assign sw_start_o       = lnk.start;
  assign sw_enable_o      = lnk.sw_enable;
  assign sw_vector_addr_o = cur_reg.vaddr;

  // ***********************************************************
  // Checks
  // ***********************************************************
  a_status_layout: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    rd_status |=> rdata_o[3:0] == $past({cur_reg.enable, lnk.flag}))
    else $error("status read does not show enables and flags");

  a_irq_gate_second: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    event_second_i && !wr_status
    |=> irq_second_o == $past(cur_reg.enable[1]))
    else $error("second interrupt does not follow its enable");

  a_irq_gate_first: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    event_first_i && !wr_status
    |=> irq_first_o == $past(cur_reg.enable[0]))
    else $error("first interrupt does not follow its enable");

  a_event_sets_second: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    event_second_i
    |=> lnk.flag[1] && ($past(rd_vector) || rdata_o[7:4] == 4'h0))
    else $error("second flag not set by its event");

  a_event_sets_first: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    event_first_i ##1 (!wr_status && !xfer_ack_first_i) ##1 rd_status
    |=> rdata_o[0])
    else $error("first flag not set or not visible on read");

  a_flag_xfer_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    xfer_ack_first_i && !interrupt_select_bit_i && !event_first_i
    |=> !lnk.flag[0])
    else $error("first flag not cleared by transfer activation");

  a_flag_read_write: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (rd_status && lnk.flag[1] && !xfer_ack_second_i)
    ##1 !event_second_i
    ##1 (wr_status && !wdata_i[1] && !event_second_i)
    |=> !lnk.flag[1])
    else $error("second flag not cleared by read one then write zero");

  a_flag_kept_select: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    xfer_ack_second_i && interrupt_select_bit_i && lnk.flag[1] && !wr_status
    |=> lnk.flag[1])
    else $error("second flag lost while select bit is one");

  a_trigger_start: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    wr_vector && wdata_i[7] && !lnk.sw_enable
    |=> sw_start_o && sw_enable_o ##1 !sw_start_o)
    else $error("software trigger did not start for one cycle");

  a_trigger_autoclear: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    sw_enable_o && sw_run_done_i && !interrupt_select_bit_i && !count_end_i
    && !wr_vector |=> !sw_enable_o)
    else $error("trigger enable not cleared after plain run");

  a_trigger_select_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (sw_enable_o && sw_end_irq_i && !wr_vector)
    ##[1:8] (select_zero_wr_i && !wr_vector) |=> !sw_enable_o)
    else $error("trigger enable not cleared by select write zero");

  a_trigger_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    sw_enable_o && sw_run_done_i && (interrupt_select_bit_i || count_end_i)
    && !wr_vector && !select_zero_wr_i |=> sw_enable_o)
    else $error("trigger enable dropped after run with select set");

  a_vector_address: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    wr_vector && !lnk.sw_enable
    |=> sw_vector_addr_o == vec_addr($past(wdata_i[6:0])))
    else $error("vector address not formed from written number");

  a_vector_locked: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    wr_vector && lnk.sw_enable |=> $stable(cur_reg.vector))
    else $error("vector number changed while trigger enabled");

  a_vector_readback: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    rd_vector |=> rdata_o == {$past(lnk.sw_enable), $past(cur_reg.vector)})
    else $error("vector register read back wrong");

  a_read_idle_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside the read answer cycle");

  a_status_high_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    rd_status |=> rdata_o[7:4] == 4'h0)
    else $error("status read shows nonzero reserved bits");

endmodule // event_irq_and_sw_transfer_trigger

//--- include/evirq_cfg.svh
/*
  Constants for the event interrupt and software trigger block: register
  addresses, field positions, reset values and the vector base.
  Assumes an 8-bit register port with 24-bit byte addresses.
*/
`ifndef EVIRQ_CFG_SVH
`define EVIRQ_CFG_SVH

// ***********************************************************
// Register addresses
// ***********************************************************
`define EVIRQ_ADDR_W          24
`define EVIRQ_STATUS_ADDR     24'hff0528
`define EVIRQ_VECTOR_ADDR     24'hff053d

// ***********************************************************
// Reset values and field positions
// ***********************************************************
`define EVIRQ_STATUS_RESET    8'h00
`define EVIRQ_VECTOR_RESET    8'h00
`define EVIRQ_BIT_EN_SECOND   3
`define EVIRQ_BIT_EN_FIRST    2
`define EVIRQ_BIT_FLAG_SECOND 1
`define EVIRQ_BIT_FLAG_FIRST  0
`define EVIRQ_BIT_SW_ENABLE   7
`define EVIRQ_VEC_MSB         6
`define EVIRQ_VEC_BASE        16'h0400

`endif

//--- include/evirq_pkg.sv
/*
  Types for the event interrupt and software trigger block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package evirq_pkg;

  // Software trigger states, Gray along idle, run, hold
  typedef enum logic [1:0] {
    TRG_IDLE = 2'b00,
    TRG_RUN  = 2'b01,
    TRG_HOLD = 2'b11
  } trig_state_t;

  typedef struct packed {
    logic [1:0] flag;
    logic [1:0] armed;
  } flag_regs_t;

  typedef struct packed {
    trig_state_t state;
    logic        start;
  } trig_regs_t;

  typedef struct packed {
    logic [7:0]  rdata;
    logic [1:0]  enable;
    logic [6:0]  vector;
    logic [15:0] vaddr;
  } top_regs_t;

endpackage

//--- include/evirq_if.sv
/*
  Internal carrier between the top of the block, its flag bank and its
  software trigger controller. Assumes one clock domain.
*/
`timescale 1ns/1ps
interface evirq_if;
  logic [1:0] ev_set;
  logic [1:0] rd_arm;
  logic [1:0] wr_zero;
  logic [1:0] xfer_clr;
  logic [1:0] flag;
  logic       sw_wr_one;
  logic       sw_wr_zero;
  logic       run_done;
  logic       count_end;
  logic       interrupt_select_bit;
  logic       end_irq;
  logic       select_zero_wr;
  logic       sw_enable;
  logic       start;

  modport flag_mp (input ev_set, rd_arm, wr_zero, xfer_clr, output flag);
  modport trig_mp (input sw_wr_one, sw_wr_zero, run_done, count_end,
                   input interrupt_select_bit, end_irq, select_zero_wr,
                   output sw_enable, start);
  modport top_mp (output ev_set, rd_arm, wr_zero, xfer_clr,
                  output sw_wr_one, sw_wr_zero, run_done, count_end,
                  output interrupt_select_bit, end_irq, select_zero_wr,
                  input flag, sw_enable, start);
endinterface

//--- rtl/event_flag_bank.sv
/*
  The two event flags: set by events, cleared by read-one/write-zero or
  by a transfer run. Assumes a synchronised active-low reset.
*/
`timescale 1ns/1ps
module event_flag_bank (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Link to the top
  evirq_if.flag_mp  lnk
);

  evirq_pkg::flag_regs_t cur_reg;
  evirq_pkg::flag_regs_t cur_next;

  always_comb begin
    cur_next = cur_reg;
    for (int i = 0; i < 2; i++) begin
      if (lnk.rd_arm[i]) begin
        cur_next.armed[i] = cur_reg.flag[i];
      end
      if ((lnk.wr_zero[i] && cur_reg.armed[i]) || lnk.xfer_clr[i]) begin
        cur_next.flag[i]  = 1'b0;
        cur_next.armed[i] = 1'b0;
      end
      if (lnk.ev_set[i]) begin
        cur_next.flag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign lnk.flag = cur_reg.flag;

endmodule // event_flag_bank

//--- rtl/sw_trigger_ctrl.sv
/*
  Software trigger enable bit and its set and clear sequence.
  Assumes a synchronised active-low reset and one-cycle inputs except interrupt_select_bit and count_end.
*/
`timescale 1ns/1ps
module sw_trigger_ctrl (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Link to the top
  evirq_if.trig_mp  lnk
);

  evirq_pkg::trig_regs_t cur_reg;
  evirq_pkg::trig_regs_t cur_next;

  always_comb begin
    cur_next       = cur_reg;
    cur_next.start = 1'b0;
    case (cur_reg.state)
      evirq_pkg::TRG_IDLE: begin
      end
      evirq_pkg::TRG_RUN: begin
        if (lnk.run_done && !lnk.interrupt_select_bit && !lnk.count_end) begin
          cur_next.state = evirq_pkg::TRG_IDLE;
        end else if (lnk.run_done || lnk.end_irq) begin
          cur_next.state = evirq_pkg::TRG_HOLD;
        end
      end
      evirq_pkg::TRG_HOLD: begin
        if (lnk.select_zero_wr) begin
          cur_next.state = evirq_pkg::TRG_IDLE;
        end
      end
      default: cur_next.state = evirq_pkg::TRG_IDLE;
    endcase
    if (lnk.sw_wr_zero) begin
      cur_next.state = evirq_pkg::TRG_IDLE;
    end
    if (lnk.sw_wr_one && cur_next.state == evirq_pkg::TRG_IDLE) begin
      cur_next.state = evirq_pkg::TRG_RUN;
      cur_next.start = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign lnk.sw_enable = (cur_reg.state != evirq_pkg::TRG_IDLE);
  assign lnk.start     = cur_reg.start;

endmodule // sw_trigger_ctrl

//--- verification/xfer_ctrl_model.sv
/*
  Behavioural transfer controller on the far side of the block.
  Assumes one clock and the block's one-cycle pulse conventions.
*/
`timescale 1ns/1ps
module xfer_ctrl_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Bench controls
  input  wire logic       ack_en_i,
  input  wire logic       select_cfg_i,
  input  wire logic       count_end_cfg_i,
  input  wire logic [3:0] delay_i,
  // Block side
  input  wire logic       irq_second_i,
  input  wire logic       irq_first_i,
  input  wire logic       sw_start_i,
  output logic            xfer_ack_second_o,
  output logic            xfer_ack_first_o,
  output logic            interrupt_select_bit_o,
  output logic            count_end_o,
  output logic            sw_run_done_o,
  output logic            sw_end_irq_o
);
  logic [3:0] wait_cnt;
  logic       busy;

  // ***********************************************************
  // Activation and completion
  // ***********************************************************
  assign interrupt_select_bit_o = select_cfg_i;
  assign count_end_o            = count_end_cfg_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xfer_ack_second_o <= 1'b0;
      xfer_ack_first_o  <= 1'b0;
      sw_run_done_o     <= 1'b0;
      sw_end_irq_o      <= 1'b0;
      busy              <= 1'b0;
      wait_cnt          <= 4'h0;
    end else begin
      xfer_ack_second_o <= ack_en_i & irq_second_i;
      xfer_ack_first_o  <= ack_en_i & irq_first_i;
      sw_run_done_o     <= 1'b0;
      sw_end_irq_o      <= 1'b0;
      if (sw_start_i) begin
        busy     <= 1'b1;
        wait_cnt <= delay_i;
      end else if (busy && wait_cnt == 4'h0) begin
        busy          <= 1'b0;
        sw_run_done_o <= 1'b1;
        sw_end_irq_o  <= select_cfg_i | count_end_cfg_i;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule // xfer_ctrl_model

//--- verification/event_irq_and_sw_transfer_trigger_tb.sv
/*
  Self-checking bench for the event flags and the software trigger.
  Assumes the register addresses and reset values of evirq_cfg.svh.
*/
`timescale 1ns/1ps
`include "evirq_cfg.svh"
module event_irq_and_sw_transfer_trigger_tb;
  logic        clk_i, reset_n_i, wr_i, rd_i;
  logic [23:0] addr_i;
  logic [7:0]  wdata_i, rdata_o;
  logic        event_second_i, event_first_i, irq_second_o, irq_first_o;
  logic        xfer_ack_second_i, xfer_ack_first_i, interrupt_select_bit_i;
  logic        sw_run_done_i, count_end_i, sw_end_irq_i, select_zero_wr_i;
  logic        sw_start_o, sw_enable_o;
  logic [15:0] sw_vector_addr_o;
  logic        ack_en, select_cfg, count_end_cfg;
  logic [3:0]  delay;
  int          failures, n_checks;
  logic [6:0]  vec_tab [4] = '{7'h00, 7'h01, 7'h40, 7'h7f};

  event_irq_and_sw_transfer_trigger event_irq_and_sw_transfer_trigger_inst (
    .clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .event_second_i, .event_first_i, .irq_second_o, .irq_first_o,
    .xfer_ack_second_i, .xfer_ack_first_i, .interrupt_select_bit_i,
    .sw_run_done_i, .count_end_i, .sw_end_irq_i, .select_zero_wr_i,
    .sw_start_o, .sw_enable_o, .sw_vector_addr_o);

  xfer_ctrl_model xfer_ctrl_model_inst (
    .clk_i, .reset_n_i, .ack_en_i(ack_en), .select_cfg_i(select_cfg),
    .count_end_cfg_i(count_end_cfg), .delay_i(delay),
    .irq_second_i(irq_second_o), .irq_first_i(irq_first_o),
    .sw_start_i(sw_start_o), .xfer_ack_second_o(xfer_ack_second_i),
    .xfer_ack_first_o(xfer_ack_first_i),
    .interrupt_select_bit_o(interrupt_select_bit_i),
    .count_end_o(count_end_i), .sw_run_done_o(sw_run_done_i),
    .sw_end_irq_o(sw_end_irq_i));

  // ***********************************************************
  // Tasks
  // ***********************************************************
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [23:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(what, {8'h00, exp}, {8'h00, rdata_o});
  endtask

  task automatic fire(input logic second);
    @(posedge clk_i);
    event_second_i <= second;
    event_first_i  <= ~second;
    @(posedge clk_i);
    event_second_i <= 1'b0;
    event_first_i  <= 1'b0;
    #1;
  endtask

  task automatic wait_sig(input logic want_done, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if (want_done ? sw_run_done_i === 1'b1 : sw_enable_o === 1'b0) break;
      @(posedge clk_i);
      #1;
    end
    if (i == n) begin
      failures++;
      report_and_stop();
    end
  endtask

  // ***********************************************************
  // Clock, reset and watchdog
  // ***********************************************************
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  initial begin
    {reset_n_i, wr_i, rd_i, event_second_i, event_first_i} = '0;
    {ack_en, select_cfg, count_end_cfg, select_zero_wr_i} = '0;
    addr_i  = 24'h000000;
    wdata_i = 8'h00;
    delay   = 4'ha;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check("vector address", 16'h0400, sw_vector_addr_o);
    rd_chk(`EVIRQ_STATUS_ADDR, `EVIRQ_STATUS_RESET, "status reset");
    rd_chk(`EVIRQ_VECTOR_ADDR, `EVIRQ_VECTOR_RESET, "vector reset");
    reg_wr(24'hff0529, 8'hff);
    rd_chk(24'hff0529, 8'h00, "unmapped");
    reg_wr(`EVIRQ_STATUS_ADDR, 8'hff);
    rd_chk(`EVIRQ_STATUS_ADDR, 8'h0c, "status ones");
    reg_wr(`EVIRQ_STATUS_ADDR, 8'h00);
    fire(1'b0);
    check("irq first off", 16'h0, {15'h0, irq_first_o});
    rd_chk(`EVIRQ_STATUS_ADDR, 8'h01, "first flag");
    reg_wr(`EVIRQ_STATUS_ADDR, 8'h05);
    check("irq first on", 16'h1, {15'h0, irq_first_o});
    fire(1'b1);
    check("irq second off", 16'h0, {15'h0, irq_second_o});
    reg_wr(`EVIRQ_STATUS_ADDR, 8'h0f);
    check("irq second on", 16'h1, {15'h0, irq_second_o});
    reg_wr(`EVIRQ_STATUS_ADDR, 8'h0c);
    rd_chk(`EVIRQ_STATUS_ADDR, 8'h0e, "clear after read");
    check("irq first clear", 16'h0, {15'h0, irq_first_o});
    reg_wr(`EVIRQ_STATUS_ADDR, 8'h0c);
    rd_chk(`EVIRQ_STATUS_ADDR, 8'h0c, "second clear");
    fire(1'b1);
    fire(1'b0);
    @(posedge clk_i);
    select_cfg <= 1'b1;
    ack_en     <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    check("keep on select", 16'h3, {14'h0, irq_second_o, irq_first_o});
    @(posedge clk_i);
    select_cfg <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    check("ack clears", 16'h0, {14'h0, irq_second_o, irq_first_o});
    @(posedge clk_i);
    ack_en <= 1'b0;
    rd_chk(`EVIRQ_STATUS_ADDR, 8'h0c, "after ack");
    reg_wr(`EVIRQ_VECTOR_ADDR, 8'h90);
    check("start", 16'h1, {15'h0, sw_start_o});
    check("vector 10", 16'h0420, sw_vector_addr_o);
    reg_wr(`EVIRQ_VECTOR_ADDR, 8'h85);
    check("no restart", 16'h0, {15'h0, sw_start_o});
    rd_chk(`EVIRQ_VECTOR_ADDR, 8'h90, "vector held");
    wait_sig(1'b0, 40);
    rd_chk(`EVIRQ_VECTOR_ADDR, 8'h10, "auto clear");
    for (int k = 0; k < 4; k++) begin
      reg_wr(`EVIRQ_VECTOR_ADDR, {1'b1, vec_tab[k]});
      check("vector addr", 16'h0400 + 16'(vec_tab[k]) * 16'd2,
            sw_vector_addr_o);
      check("enable", 16'h1, {15'h0, sw_enable_o});
      wait_sig(1'b0, 40);
    end
    reg_wr(`EVIRQ_VECTOR_ADDR, 8'h00);
    check("no start on 0", 16'h0, {15'h0, sw_start_o});
    @(posedge clk_i);
    select_cfg <= 1'b1;
    reg_wr(`EVIRQ_VECTOR_ADDR, 8'h80);
    wait_sig(1'b1, 40);
    repeat (3) @(posedge clk_i);
    #1;
    check("held on select", 16'h1, {15'h0, sw_enable_o});
    @(posedge clk_i);
    select_zero_wr_i <= 1'b1;
    @(posedge clk_i);
    select_zero_wr_i <= 1'b0;
    wait_sig(1'b0, 3);
    check("select zero clears", 16'h0, {15'h0, sw_enable_o});
    @(posedge clk_i);
    select_cfg    <= 1'b0;
    count_end_cfg <= 1'b1;
    reg_wr(`EVIRQ_VECTOR_ADDR, 8'h80);
    wait_sig(1'b1, 40);
    repeat (3) @(posedge clk_i);
    #1;
    check("held on count", 16'h1, {15'h0, sw_enable_o});
    reg_wr(`EVIRQ_VECTOR_ADDR, 8'h00);
    check("write zero", 16'h0, {15'h0, sw_enable_o});
    report_and_stop();
  end
endmodule // event_irq_and_sw_transfer_trigger_tb
